// file: core/lin_transmit_fault_guard.sv
`timescale 1ns/100ps
`default_nettype none
module lin_transmit_fault_guard #(
  parameter int unsigned CLAMP_LEN = lin_guard_pkg::CLAMP_CYC
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rstn,
  input  wire lin_guard_pkg::host_in_type i_host,
  input  wire logic                       i_overtemp,
  input  wire logic                       i_bus_rx,
  input  wire logic                       i_rxd_pin,
  output logic                            o_bus_drv_dom,
  output logic                            o_rxd,
  output lin_guard_pkg::status_type       o_status
);
  import lin_guard_pkg::*;

  tx_state_type     state_q;       // thermal gate state
  tx_state_type     state_d;       // next thermal gate state
  logic             txd_q;         // previous transmit input
  logic             clamp_q;       // clamp fault flag
  logic             wake_q;        // wake pulse register
  logic             wake_seen_q;   // wake already reported for phase
  logic [CNT_W-1:0] clamp_cnt_q;   // coincidence counter
  logic [CNT_W-1:0] dom_cnt_q;     // dominant phase length counter
  logic             rxd_q;         // registered receive output

  // decode wires
  wire txd_rise     = ~txd_q & i_host.txd;
  wire thermal_ok   = (state_q == TX_RUN);
  wire coincide     = ~i_bus_rx & i_rxd_pin;
  wire clamp_hit    = coincide && (clamp_cnt_q >= CNT_W'(CLAMP_LEN - 1));
  wire tx_gate      = thermal_ok & ~i_overtemp & ~clamp_q
                      & ~i_host.rx_only & ~i_host.wake_cap;
  wire wake_hit     = i_host.wake_cap && !wake_seen_q && !i_bus_rx
                      && (dom_cnt_q >= CNT_W'(WAKE_FILT_CYC - 1));

  // thermal gate next state
  // wait for edge
  always_comb begin
    state_d = state_q;
    case (state_q)
      TX_RUN:  if (i_overtemp) state_d = TX_HOT;  // shut driver
      TX_HOT:  if (!i_overtemp) state_d = TX_ARM; // cooled, arm
      TX_ARM: begin
        if (i_overtemp) state_d = TX_HOT;         // heated again
        else if (txd_rise) state_d = TX_RUN;      // recessive edge
      end
      default: state_d = TX_HOT;                  // safe recovery
    endcase
  end

  // thermal state register
  // automatic receive-only entry
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) state_q <= TX_RUN;
    else         state_q <= state_d;
  end

  // transmit input history for edge detection
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) txd_q <= LVL_RECESSIVE;
    else         txd_q <= i_host.txd;
  end

  // coincidence counter for clamp detection
  // consecutive cycle count
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)       clamp_cnt_q <= CNT_RST;
    else if (!coincide) clamp_cnt_q <= CNT_RST;
    else if (!clamp_hit) clamp_cnt_q <= clamp_cnt_q + CNT_W'(1);
  end

  // clamp fault flag, detection wins over resume
  // flag clamp fault
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)              clamp_q <= 1'b0;
    else if (clamp_hit)       clamp_q <= 1'b1;
    else if (i_host.resume)   clamp_q <= 1'b0;
  end

  // dominant phase length counter, saturating
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)        dom_cnt_q <= CNT_RST;
    else if (i_bus_rx)  dom_cnt_q <= CNT_RST;
    else if (dom_cnt_q != {CNT_W{1'b1}})
      dom_cnt_q <= dom_cnt_q + CNT_W'(1);
  end

  // qualified wake pulse, once per dominant phase
  // filter dominant time
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wake_q      <= 1'b0;
      wake_seen_q <= 1'b0;
    end else begin
      wake_q      <= wake_hit;
      wake_seen_q <= i_bus_rx ? 1'b0 : (wake_seen_q | wake_hit);
    end
  end

  // driver and receive output registers
  // driver off when hot
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bus_drv_dom <= 1'b0;
      rxd_q         <= LVL_RECESSIVE;
    end else begin
      o_bus_drv_dom <= tx_gate & ~i_host.txd;
      rxd_q         <= i_bus_rx;
    end
  end

  assign o_rxd = rxd_q;
  // overtemperature has no status bit here
  // no thermal report
  // one driver for the whole status struct
  assign o_status = status_type'{
    clamp_fault: clamp_q,
    wake:        wake_q,
    tx_blocked:  ~o_bus_drv_dom & ~tx_gate
  };

  // checks
  property p_hot_no_drive;
    @(posedge i_clk) disable iff (!i_rstn)
      i_overtemp |=> !o_bus_drv_dom;
  endproperty
  a_hot_no_drive: assert property (p_hot_no_drive)
    else $error("driver active during overtemperature");

  property p_hot_rx_pass;
    @(posedge i_clk) disable iff (!i_rstn)
      i_overtemp |=> (o_rxd == $past(i_bus_rx));
  endproperty
  a_hot_rx_pass: assert property (p_hot_rx_pass)
    else $error("rxd not following bus while hot");

  property p_need_edge;
    @(posedge i_clk) disable iff (!i_rstn)
      (state_q == TX_ARM && !txd_rise) |=> state_q != TX_RUN;
  endproperty
  a_need_edge: assert property (p_need_edge)
    else $error("transmit released without recessive edge");

  property p_no_report;
    @(posedge i_clk) disable iff (!i_rstn)
      ($rose(i_overtemp) && !clamp_q && !clamp_hit) |=> !o_status.clamp_fault;
  endproperty
  a_no_report: assert property (p_no_report)
    else $error("overtemperature leaked into diagnostics");

  property p_clamp_block;
    @(posedge i_clk) disable iff (!i_rstn)
      clamp_q |=> !o_bus_drv_dom;
  endproperty
  a_clamp_block: assert property (p_clamp_block)
    else $error("driver active with clamp fault");

  property p_clamp_hold;
    @(posedge i_clk) disable iff (!i_rstn)
      (clamp_q && !i_host.resume) |=> clamp_q;
  endproperty
  a_clamp_hold: assert property (p_clamp_hold)
    else $error("clamp cleared without command");

  property p_wake_len;
    @(posedge i_clk) disable iff (!i_rstn)
      $rose(wake_q) |-> $past(dom_cnt_q) >= CNT_W'(WAKE_MIN_CYC - 1);
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("wake on short dominant phase");

  property p_rx_only;
    @(posedge i_clk) disable iff (!i_rstn)
      i_host.rx_only |=> !o_bus_drv_dom;
  endproperty
  a_rx_only: assert property (p_rx_only)
    else $error("driver active in receive-only");

  property p_clamp_count;
    @(posedge i_clk) disable iff (!i_rstn)
      $rose(clamp_q) |-> $past(coincide);
  endproperty
  a_clamp_count: assert property (p_clamp_count)
    else $error("clamp set without coincidence");

  // wake filter must stay inside the allowed window
  property p_wake_max;
    @(posedge i_clk) disable iff (!i_rstn)
      $rose(wake_q) |-> $past(dom_cnt_q) < CNT_W'(WAKE_MAX_CYC);
  endproperty
  a_wake_max: assert property (p_wake_max)
    else $error("wake filter longer than allowed");

  // reception keeps running in receive-only mode
  property p_rx_only_pass;
    @(posedge i_clk) disable iff (!i_rstn)
      i_host.rx_only |=> (o_rxd == $past(i_bus_rx));
  endproperty
  a_rx_only_pass: assert property (p_rx_only_pass)
    else $error("rxd not following bus in receive-only");

  // clamp needs the full run of coincident cycles
  property p_clamp_len;
    @(posedge i_clk) disable iff (!i_rstn)
      $rose(clamp_q) |-> ($past(clamp_cnt_q) == CNT_W'(CLAMP_LEN - 1));
  endproperty
  a_clamp_len: assert property (p_clamp_len)
    else $error("clamp set before full coincidence count");

  c_hot: cover property (@(posedge i_clk) disable iff (!i_rstn)
    state_q == TX_ARM ##1 state_q == TX_RUN);
  c_clamp: cover property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(clamp_q));
  c_wake: cover property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(wake_q));
  c_resume: cover property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(clamp_q));

endmodule : lin_transmit_fault_guard
`default_nettype wire

// file: core/lin_guard_pkg.sv
package lin_guard_pkg;

  // clock rate in kHz (10 MHz)
  localparam int unsigned CLK_KHZ            = 10000;
  // wake filter window in microseconds
  localparam int unsigned WAKE_MIN_US        = 30;
  localparam int unsigned WAKE_MAX_US        = 150;
  // least time rounds up, longest time rounds down
  localparam int unsigned WAKE_MIN_CYC       = (WAKE_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned WAKE_MAX_CYC       = (WAKE_MAX_US * CLK_KHZ) / 1000;
  // chosen filter length inside the window
  localparam int unsigned WAKE_FILT_CYC      = WAKE_MIN_CYC + 1;
  // default clamp detection length in cycles
  localparam int unsigned CLAMP_CYC          = 16;
  localparam int unsigned CNT_W              = 12;
  // counter reset value
  localparam logic [CNT_W-1:0] CNT_RST       = 12'h000;
  // idle recessive level of txd history and rxd after reset
  localparam logic             LVL_RECESSIVE = 1'b1;

  // transmitter gate state, one-hot
  typedef enum logic [2:0] {
    TX_RUN  = 3'h1,
    TX_HOT  = 3'h2,
    TX_ARM  = 3'h4
  } tx_state_type;

  // pin group from the protocol handler side
  typedef struct packed {
    logic txd;      // transmit input, 0 = dominant
    logic rx_only;  // receive-only mode selected by software
    logic wake_cap; // wake-capable mode selected
    logic resume;   // software resume command pulse
  } host_in_type;

  // status group towards the system basis chip
  typedef struct packed {
    logic clamp_fault; // diagnosed recessive clamp
    logic wake;        // qualified bus wake-up pulse
    logic tx_blocked;  // driver held inactive
  } status_type;

endpackage : lin_guard_pkg

// file: bench/lin_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// protocol handler pins, launched one delay after each rising edge
module lin_host_model (
  input  wire logic                      i_clk,
  input  wire logic                      i_txd,
  input  wire logic                      i_rx_only,
  input  wire logic                      i_wake_cap,
  input  wire logic                      i_resume,
  output var lin_guard_pkg::host_in_type o_host
);
  import lin_guard_pkg::*;
  // idle recessive before the first edge
  initial o_host = 4'h8;
  always @(posedge i_clk) begin
    o_host <= #1 {i_txd, i_rx_only, i_wake_cap, i_resume};
  end
endmodule : lin_host_model
`default_nettype wire

// file: bench/lin_transmit_fault_guard_bench.sv
`timescale 1ns/100ps
`default_nettype none
module lin_transmit_fault_guard_bench;
  import lin_guard_pkg::*;
  localparam int unsigned LEN = 4; // short clamp count
  logic        i_clk, i_rstn, ot, brx, rpin, txd, rxo, wk, res, drv, rxd;
  host_in_type host;
  status_type  st;
  int          mismatches, tests_run, mst, cnt, flt, ptx, wakes, edrv;
  lin_host_model host_m (.i_clk(i_clk), .i_txd(txd), .i_rx_only(rxo),
    .i_wake_cap(wk), .i_resume(res), .o_host(host));
  lin_transmit_fault_guard #(.CLAMP_LEN(LEN)) dut (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_host(host), .i_overtemp(ot), .i_bus_rx(brx),
    .i_rxd_pin(rpin), .o_bus_drv_dom(drv), .o_rxd(rxd), .o_status(st));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // reference model: 0 run, 1 hot, 2 armed; clamp count and flag
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      {mst, cnt, flt, ptx, edrv} = {32'd0, 32'd0, 32'd0, 32'd1, 32'd0};
    end else begin
      // driver expected at this edge, from pre-edge state
      edrv = int'(mst == 0 && flt == 0 && !host.rx_only && !host.wake_cap
        && !ot && !host.txd);
      if (ot) mst = 1;
      else if (mst == 1) mst = 2;
      else if (mst == 2 && ptx == 0 && host.txd) mst = 0;
      ptx = host.txd;
      cnt = (!brx && rpin) ? cnt + 1 : 0;
      if (cnt >= LEN) flt = 1;
      else if (host.resume) flt = 0;
      if (st.wake === 1'b1) wakes++;
    end
  end
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic s, input logic e, input string m);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick
  // let inputs settle, then compare driver and clamp flag with the model and receive output with the bus
  task automatic look();
    repeat (4) tick();
    chk(drv, edrv[0], "driver");
    chk(rxd, brx, "receive out");
    chk(st.clamp_fault, flt[0], "clamp flag");
  endtask : look
  initial begin
    {ot, brx, rpin, txd, rxo, wk, res} = 7'h38;
    {i_rstn, mismatches, tests_run, wakes} = '0;
    void'($urandom(71));
    repeat (12) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    // random traffic in normal mode
    repeat (20) begin
      tick();
      {txd, brx} = 2'($urandom);
      rpin = brx;
      look();
    end
    tick();
    {rxo, txd, brx, rpin} = 4'h8;
    look();
    tick();
    {rxo, ot} = 2'b01;
    look();
    chk(st.tx_blocked, 1'b1, "thermal block");
    chk(st.clamp_fault, 1'b0, "thermal hidden");
    tick();
    ot = 1'b0;
    look();
    tick();
    txd = 1'b1;
    look();
    tick();
    txd = 1'b0;
    look();
    tick();
    {brx, rpin} = 2'b01;
    repeat (LEN - 1) tick();
    rpin = 1'b0;
    look();
    tick();
    rpin = 1'b1;
    look();
    tick();
    {brx, rpin} = 2'b11;
    look();
    tick();
    res = 1'b1;
    tick();
    res = 1'b0;
    look();
    tick();
    {wk, brx, rpin} = 3'b100;
    repeat (295) tick();
    brx = 1'b1;
    look();
    chk(wakes == 0, 1'b1, "short wake taken");
    tick();
    brx = 1'b0;
    repeat (320) tick();
    brx = 1'b1;
    look();
    chk(wakes == 1, 1'b1, "wake missing");
    give_verdict();
  end
  // hang guard well beyond the planned run
  initial begin
    #(20000 * 100);
    mismatches++;
    give_verdict();
  end
endmodule : lin_transmit_fault_guard_bench
`default_nettype wire
